// file: rtl/pviu_pkg.sv
// package of the vectored interrupt unit: register map, bit positions, event carrier
// assumes one clock domain and an AXI4-Lite register port with 32-bit data
package pviu_pkg;

  localparam int unsigned PVIU_NREG   = 11;
  localparam int unsigned PVIU_NSRC   = 15;
  localparam int unsigned PVIU_NMF    = 6;
  localparam int unsigned PVIU_AXI_AW = 8;

  // register indices; byte address is index times four
  localparam logic [3:0] PVIU_IDX_PRIM0 = 4'h0;
  localparam logic [3:0] PVIU_IDX_PRIM1 = 4'h1;
  localparam logic [3:0] PVIU_IDX_GRP0  = 4'h4;
  localparam logic [3:0] PVIU_IDX_GRP4  = 4'h8;
  localparam logic [3:0] PVIU_IDX_GRP5  = 4'h9;
  localparam logic [3:0] PVIU_IDX_EDGE  = 4'ha;
  localparam logic [3:0] PVIU_IDX_LAST  = 4'ha;

  localparam logic [7:0] PVIU_RST_VAL = 8'h00;
  localparam int unsigned PVIU_GIE_BIT = 0;

  // writable bits per register, index 10 first
  localparam logic [10:0][7:0] PVIU_WMASK = {
    8'h0f, 8'hff, 8'hff, 8'h33, 8'h33, 8'h33, 8'h33, 8'hff, 8'hff, 8'hff, 8'h7f};
  // request flag bits per register, index 10 first
  localparam logic [10:0][7:0] PVIU_FMASK = {
    8'h00, 8'hf0, 8'hf0, 8'h30, 8'h30, 8'h30, 8'h30, 8'hf0, 8'hf0, 8'hf0, 8'h70};

  // enable and flag positions in the four primary registers, lowest vector at index 0
  localparam logic [14:0][4:0] PVIU_EN_POS = {
    5'd27, 5'd26, 5'd25, 5'd24, 5'd19, 5'd18, 5'd17, 5'd16,
    5'd11, 5'd10, 5'd9, 5'd8, 5'd3, 5'd2, 5'd1};
  localparam logic [14:0][4:0] PVIU_FL_POS = {
    5'd31, 5'd30, 5'd29, 5'd28, 5'd23, 5'd22, 5'd21, 5'd20,
    5'd15, 5'd14, 5'd13, 5'd12, 5'd6, 5'd5, 5'd4};
  // source index of each multi-function vector 0..5
  localparam logic [5:0][3:0] PVIU_MF_SRC = {4'd14, 4'd9, 4'd8, 4'd7, 4'd6, 4'd5};
  localparam logic [3:0] PVIU_SRC_USB = 4'd2;

  localparam logic [7:0] PVIU_VEC_STEP = 8'h04;

  localparam logic [1:0] PVIU_EDGE_OFF  = 2'b00;
  localparam logic [1:0] PVIU_EDGE_RISE = 2'b01;
  localparam logic [1:0] PVIU_EDGE_FALL = 2'b10;
  localparam logic [1:0] PVIU_EDGE_BOTH = 2'b11;

  localparam logic [1:0] PVIU_RESP_OKAY   = 2'b00;
  localparam logic [1:0] PVIU_RESP_SLVERR = 2'b10;

  // one-cycle event pulses from peripherals on the system clock
  typedef struct packed {
    logic       usb;
    logic       cmp0;
    logic       cmp1;
    logic       serial_module;
    logic       spi_a;
    logic       timebase0;
    logic       timebase1;
    logic       std_timer_p;
    logic       std_timer_a;
    logic [4:0] ptm_p;
    logic [4:0] ptm_a;
    logic       low_voltage;
    logic       uart;
    logic       converter;
    logic       eeprom;
  } pviu_events_t;

endpackage

// file: rtl/pviu_top.sv
// vectored, prioritised interrupt unit with its return stack and register port
// assumes peripheral events synchronous to CLK, pins asynchronous, core sequencer on CLK
// Behaviour
// - source event sets its request flag
// - flag vectors only when its enable set
// - global enable low blocks every interrupt
// - push next address, load winning vector
// - return from interrupt pops saved address
// - service clears global enable automatically
// - requests while blocked still set flags
// - full stack blocks acknowledgement until pop
// - fixed priority, lowest vector wins
// - any flag becoming set wakes device
// - dedicated vectors plus shared grouped vectors
// - first primary register layout
// - second primary register layout
// - third primary register layout
// - fourth primary register layout
// - first grouped register: standard timer
// - grouped registers one..three: periodic timers
// - fifth grouped register: timers three, four
// - sixth grouped register: voltage, uart, converter, eeprom
// - flags and enables read/write, reset zero
// - service clears dedicated source flag
// - pin edge select: off, rise, fall, both
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module pviu_top
  import pviu_pkg::*;
#(
  parameter int unsigned PC_W        = 16,
  parameter int unsigned STACK_DEPTH = 8
) (
  input  wire logic                   CLK,
  input  wire logic                   RST,
  input  wire logic                   AWVALID,
  output logic                        AWREADY,
  input  wire logic [PVIU_AXI_AW-1:0] AWADDR,
  input  wire logic                   WVALID,
  output logic                        WREADY,
  input  wire logic [31:0]            WDATA,
  input  wire logic [3:0]             WSTRB,
  output logic                        BVALID,
  input  wire logic                   BREADY,
  output logic [1:0]                  BRESP,
  input  wire logic                   ARVALID,
  output logic                        ARREADY,
  input  wire logic [PVIU_AXI_AW-1:0] ARADDR,
  output logic                        RVALID,
  input  wire logic                   RREADY,
  output logic [31:0]                 RDATA,
  output logic [1:0]                  RRESP,
  input  wire pviu_events_t           EVENTS,
  input  wire logic [1:0]             INT_PIN,
  input  wire logic [PC_W-1:0]        CORE_PC,
  input  wire logic                   CORE_BOUNDARY,
  input  wire logic                   CORE_CALL,
  input  wire logic                   CORE_RET,
  input  wire logic                   CORE_RETURN_FROM_INTERRUPT,
  output logic                        PC_LOAD,
  output logic [PC_W-1:0]             PC_LOAD_ADDR,
  output logic                        STACK_FULL,
  output logic                        WAKE
);

  localparam int unsigned SP_W = $clog2(STACK_DEPTH + 1);

  initial begin
    if (PC_W < 8 || STACK_DEPTH < 1) begin
      $error("pviu_top: PC_W must be >= 8 and STACK_DEPTH >= 1");
    end
  end

  typedef struct packed {
    logic [10:0][7:0]                 regs;
    logic [1:0]                       pin_s1;
    logic [1:0]                       pin_s2;
    logic [1:0]                       pin_s3;
    logic [STACK_DEPTH-1:0][PC_W-1:0] stack;
    logic [SP_W-1:0]                  sp;
    logic                             pc_load;
    logic                             svc;
    logic [PC_W-1:0]                  pc_addr;
    logic                             wake;
    logic                             aw_got;
    logic                             aw_hit;
    logic [3:0]                       aw_idx;
    logic                             w_got;
    logic [7:0]                       wdata;
    logic                             wbyte;
    logic                             bvalid;
    logic [1:0]                       bresp;
    logic                             rvalid;
    logic [7:0]                       rdata;
    logic [1:0]                       rresp;
  } pviu_state_t;

  pviu_state_t st;
  pviu_state_t next_st;

  function automatic logic reg_hit(input logic [PVIU_AXI_AW-1:0] a);
    reg_hit = (a[1:0] == 2'b00) && (a[PVIU_AXI_AW-1:2] <= {2'b00, PVIU_IDX_LAST});
  endfunction

  function automatic logic [3:0] reg_idx(input logic [PVIU_AXI_AW-1:0] a);
    reg_idx = a[5:2];
  endfunction

  function automatic logic [3:0] first_set(input logic [PVIU_NSRC-1:0] v);
    first_set = 4'h0;
    for (int i = PVIU_NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 4'(i);
      end
    end
  endfunction

  logic [31:0]           prim;
  logic [PVIU_NSRC-1:0]  pend;
  logic                  any_pend;
  logic [3:0]            win;
  logic [7:0]            win_vec;
  logic                  gie;
  logic                  pop_req;
  logic                  take;
  logic                  wr_now;
  logic [PC_W-1:0]       stack_top;
  logic [PVIU_NMF-1:0]   mf_level;
  logic [10:0][7:0]      evt;
  logic [10:0][7:0]      nregs;
  logic [31:0]           np;

  // pending and priority from current state
  always_comb begin
    prim = st.regs[3:0];
    for (int i = 0; i < PVIU_NSRC; i++) begin
      pend[i] = prim[PVIU_FL_POS[i]] & prim[PVIU_EN_POS[i]];
    end
    any_pend = |pend;
    win = first_set(pend);
    win_vec = 8'((win + 4'h1) * PVIU_VEC_STEP);
    gie = st.regs[PVIU_IDX_PRIM0][PVIU_GIE_BIT];
    for (int n = 0; n < PVIU_NMF; n++) begin
      mf_level[n] = |(st.regs[PVIU_IDX_GRP0 + 4'(n)][7:4]
                    & st.regs[PVIU_IDX_GRP0 + 4'(n)][3:0]);
    end
    pop_req = CORE_RET | CORE_RETURN_FROM_INTERRUPT;
    // a call or return on the same boundary is served first; the interrupt waits
    take = CORE_BOUNDARY & gie & any_pend & ~STACK_FULL
         & ~CORE_CALL & ~pop_req;
    wr_now = st.aw_got & st.w_got & ~st.bvalid;
    stack_top = (st.sp == '0) ? '0 : st.stack[st.sp - SP_W'(1)];
  end

  // peripheral and pin events mapped onto flag bits
  always_comb begin
    evt = '0;
    for (int i = 0; i < 2; i++) begin
      case (st.regs[PVIU_IDX_EDGE][2*i +: 2])
        PVIU_EDGE_RISE: evt[PVIU_IDX_PRIM0][4+i] = st.pin_s2[i] & ~st.pin_s3[i];
        PVIU_EDGE_FALL: evt[PVIU_IDX_PRIM0][4+i] = ~st.pin_s2[i] & st.pin_s3[i];
        PVIU_EDGE_BOTH: evt[PVIU_IDX_PRIM0][4+i] = st.pin_s2[i] ^ st.pin_s3[i];
        default:        evt[PVIU_IDX_PRIM0][4+i] = 1'b0;
      endcase
    end
    evt[0][6] = EVENTS.usb;
    evt[1][4] = EVENTS.cmp0;
    evt[1][5] = EVENTS.cmp1;
    evt[2][7] = EVENTS.serial_module;
    evt[3][4] = EVENTS.spi_a;
    evt[3][5] = EVENTS.timebase0;
    evt[3][6] = EVENTS.timebase1;
    evt[4][4] = EVENTS.std_timer_p;
    evt[4][5] = EVENTS.std_timer_a;
    for (int t = 0; t < 3; t++) begin
      evt[5+t][4] = EVENTS.ptm_p[t];
      evt[5+t][5] = EVENTS.ptm_a[t];
    end
    evt[PVIU_IDX_GRP4][4] = EVENTS.ptm_p[3];
    evt[PVIU_IDX_GRP4][5] = EVENTS.ptm_a[3];
    evt[PVIU_IDX_GRP4][6] = EVENTS.ptm_p[4];
    evt[PVIU_IDX_GRP4][7] = EVENTS.ptm_a[4];
    evt[PVIU_IDX_GRP5][4] = EVENTS.low_voltage;
    evt[PVIU_IDX_GRP5][5] = EVENTS.uart;
    evt[PVIU_IDX_GRP5][6] = EVENTS.converter;
    evt[PVIU_IDX_GRP5][7] = EVENTS.eeprom;
  end

  always_comb begin
    next_st = st;
    next_st.pin_s1 = INT_PIN;
    next_st.pin_s2 = st.pin_s1;
    next_st.pin_s3 = st.pin_s2;
    next_st.pc_load = 1'b0;
    next_st.svc = 1'b0;

    // register writes first, then service clears, then sets: a set always wins
    nregs = st.regs;
    if (wr_now && st.aw_hit && st.wbyte) begin
      nregs[st.aw_idx] = st.wdata & PVIU_WMASK[st.aw_idx];
    end
    np = nregs[3:0];
    if (take) begin
      np[PVIU_GIE_BIT] = 1'b0;
      np[PVIU_FL_POS[win]] = 1'b0;
    end
    nregs[3:0] = np;
    for (int n = 0; n < PVIU_NMF; n++) begin
      if (mf_level[n]) begin
        np = nregs[3:0];
        np[PVIU_FL_POS[PVIU_MF_SRC[n]]] = 1'b1;
        nregs[3:0] = np;
      end
    end
    nregs = nregs | evt;
    next_st.regs = nregs;
    next_st.wake = |((nregs & ~st.regs) & PVIU_FMASK);

    // return stack shared by calls and interrupt entries
    if (pop_req && st.sp != '0) begin
      next_st.sp = st.sp - SP_W'(1);
      next_st.pc_load = 1'b1;
      next_st.pc_addr = stack_top;
    end else if (CORE_CALL && !STACK_FULL) begin
      next_st.stack[st.sp] = CORE_PC;
      next_st.sp = st.sp + SP_W'(1);
    end else if (take) begin
      next_st.stack[st.sp] = CORE_PC;
      next_st.sp = st.sp + SP_W'(1);
      next_st.pc_load = 1'b1;
      next_st.svc = 1'b1;
      next_st.pc_addr = PC_W'(win_vec);
    end

    // register port, write side
    if (AWVALID && AWREADY) begin
      next_st.aw_got = 1'b1;
      next_st.aw_hit = reg_hit(AWADDR);
      next_st.aw_idx = reg_idx(AWADDR);
    end
    if (WVALID && WREADY) begin
      next_st.w_got = 1'b1;
      next_st.wdata = WDATA[7:0];
      next_st.wbyte = WSTRB[0];
    end
    if (wr_now) begin
      next_st.aw_got = 1'b0;
      next_st.w_got = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = st.aw_hit ? PVIU_RESP_OKAY : PVIU_RESP_SLVERR;
    end else if (st.bvalid && BREADY) begin
      next_st.bvalid = 1'b0;
    end

    // read side: unmapped reads return zero with an error response
    if (ARVALID && ARREADY) begin
      next_st.rvalid = 1'b1;
      next_st.rdata = reg_hit(ARADDR) ? st.regs[reg_idx(ARADDR)] : 8'h00;
      next_st.rresp = reg_hit(ARADDR) ? PVIU_RESP_OKAY : PVIU_RESP_SLVERR;
    end else if (st.rvalid && RREADY) begin
      next_st.rvalid = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign AWREADY = ~st.aw_got & ~st.bvalid;
  assign WREADY = ~st.w_got & ~st.bvalid;
  assign BVALID = st.bvalid;
  assign BRESP = st.bresp;
  assign ARREADY = ~st.rvalid;
  assign RVALID = st.rvalid;
  assign RDATA = {24'h000000, st.rdata};
  assign RRESP = st.rresp;
  assign PC_LOAD = st.pc_load;
  assign PC_LOAD_ADDR = st.pc_addr;
  assign STACK_FULL = (st.sp == SP_W'(STACK_DEPTH));
  assign WAKE = st.wake;

  default clocking pviu_cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  chk_event_sets_flag: assert property (EVENTS.uart |=> st.regs[PVIU_IDX_GRP5][5])
    else $error("uart event did not set its flag");
  chk_enable_gates_vector: assert property (st.svc |-> $past(any_pend))
    else $error("vector taken without enabled pending flag");
  chk_global_blocks: assert property (!gie |=> !st.svc)
    else $error("interrupt entered with global enable low");
  chk_vector_push_load: assert property (take |=> PC_LOAD && PC_LOAD_ADDR == PC_W'($past(win_vec))
                                        && st.sp == $past(st.sp) + SP_W'(1))
    else $error("entry did not push and load the vector");
  chk_return_pops: assert property (CORE_RETURN_FROM_INTERRUPT && st.sp != '0 |=>
                                    PC_LOAD && PC_LOAD_ADDR == $past(stack_top))
    else $error("return did not restore saved address");
  chk_entry_clears_gie: assert property (take && !wr_now |=> !gie ##1 !st.svc)
    else $error("global enable not cleared on entry");
  chk_full_no_ack: assert property (STACK_FULL |=> !st.svc)
    else $error("interrupt acknowledged with full stack");
  chk_lowest_wins: assert property (take |-> (pend & ((15'h0001 << win) - 15'h0001)) == '0)
    else $error("lower vector pending was skipped");
  chk_flag_wakes: assert property ($rose(st.regs[PVIU_IDX_PRIM1][4]) |-> WAKE)
    else $error("new flag did not wake");
  chk_usb_flag_cleared: assert property (take && win == PVIU_SRC_USB && !EVENTS.usb && !wr_now
                                         |=> !st.regs[PVIU_IDX_PRIM0][6])
    else $error("dedicated flag kept after service");
  chk_group_feeds_multi: assert property (mf_level[0] |=> st.regs[PVIU_IDX_PRIM1][6])
    else $error("grouped request did not raise multi flag");
  chk_full_call_ignored: assert property (CORE_CALL && STACK_FULL && !pop_req |=>
                                          st.sp == $past(st.sp))
    else $error("call pushed onto a full stack");
  chk_empty_pop_ignored: assert property (pop_req && st.sp == '0 |=> !PC_LOAD)
    else $error("return on empty stack loaded an address");
  chk_blocked_flag_kept: assert property (EVENTS.cmp1 |=> st.regs[PVIU_IDX_PRIM1][5])
    else $error("comparator event lost");
  chk_pin_edge_sets: assert property (evt[PVIU_IDX_PRIM0][4] |=> st.regs[PVIU_IDX_PRIM0][4])
    else $error("pin edge did not set its flag");
  chk_no_boundary_wait: assert property (!CORE_BOUNDARY |=> !st.svc)
    else $error("interrupt entered off an instruction boundary");
  chk_unused_bits_zero: assert property ((st.regs & ~PVIU_WMASK) == '0)
    else $error("unimplemented register bit set");
  chk_wake_has_cause: assert property (WAKE |->
                                       ((st.regs & ~$past(st.regs)) & PVIU_FMASK) != '0)
    else $error("wake without a new flag");

  cov_service: cover property (take ##1 PC_LOAD);
  cov_return: cover property (st.svc ##[1:50] (CORE_RETURN_FROM_INTERRUPT && PC_LOAD == 1'b0));
  cov_full_wait: cover property (STACK_FULL && any_pend && gie);
  cov_wake: cover property (WAKE);

endmodule

`default_nettype wire

// file: dv/pviu_core_model.sv
// core sequencer model: program counter and instruction boundary offer
// assumes the unit's PC_LOAD pulse on CLK; call and return strobes come from the bench
`timescale 1ns/1ps
`default_nettype none

module pviu_core_model
  import pviu_pkg::*;
#(
  parameter int unsigned PC_W     = 16,
  parameter logic [15:0] PC_START = 16'h0100
) (
  input  wire logic            CLK,
  input  wire logic            RST,
  input  wire logic            PC_LOAD,
  input  wire logic [PC_W-1:0] PC_LOAD_ADDR,
  input  wire logic            BOUND_EN,
  input  wire logic            SLOW,
  output logic [PC_W-1:0]      CORE_PC,
  output logic                 CORE_BOUNDARY
);
  logic phase;

  // slow mode offers a boundary only every other cycle, like multi-cycle instructions
  assign CORE_BOUNDARY = BOUND_EN & (~SLOW | phase);

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CORE_PC <= PC_W'(PC_START);
      phase   <= 1'b0;
    end else begin
      phase <= ~phase;
      // fetch resumes one past a vector or a return target
      if (PC_LOAD) CORE_PC <= PC_LOAD_ADDR + 1'b1;
    end
  end
endmodule

`default_nettype wire

// file: dv/tb.sv
// bench of the vectored interrupt unit: register tests and core service sequences
// assumes a stack depth of two so that a full stack is reachable
`timescale 1ns/1ps
`default_nettype none

module tb
  import pviu_pkg::*;
;
  logic         CLK, RST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic         ARVALID, ARREADY, RVALID, RREADY, CORE_CALL, CORE_RET, CORE_RETURN_FROM_INTERRUPT;
  logic         PC_LOAD, STACK_FULL, WAKE, CORE_BOUNDARY, bound_en, slow;
  logic [7:0]   AWADDR, ARADDR;
  logic [31:0]  WDATA, RDATA, d;
  logic [3:0]   WSTRB;
  logic [1:0]   BRESP, RRESP, INT_PIN, r;
  logic [15:0]  CORE_PC, PC_LOAD_ADDR, last_addr;
  pviu_events_t ev;
  int           bad_count = 0, n_compared = 0, n_loads = 0;
  int           pidx[6] = '{1, 1, 2, 2, 2, 3};
  logic [7:0]   pbit[6] = '{8'h40, 8'h80, 8'h10, 8'h20, 8'h40, 8'h80};

  pviu_top #(.PC_W(16), .STACK_DEPTH(2)) dut (
    .CLK(CLK), .RST(RST), .AWVALID(AWVALID), .AWREADY(AWREADY), .AWADDR(AWADDR),
    .WVALID(WVALID), .WREADY(WREADY), .WDATA(WDATA), .WSTRB(WSTRB), .BVALID(BVALID),
    .BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .ARADDR(ARADDR), .RVALID(RVALID), .RREADY(RREADY), .RDATA(RDATA), .RRESP(RRESP),
    .EVENTS(ev), .INT_PIN(INT_PIN), .CORE_PC(CORE_PC), .CORE_BOUNDARY(CORE_BOUNDARY),
    .CORE_CALL(CORE_CALL), .CORE_RET(CORE_RET), .CORE_RETURN_FROM_INTERRUPT(CORE_RETURN_FROM_INTERRUPT),
    .PC_LOAD(PC_LOAD), .PC_LOAD_ADDR(PC_LOAD_ADDR), .STACK_FULL(STACK_FULL), .WAKE(WAKE));

  pviu_core_model #(.PC_W(16)) core (
    .CLK(CLK), .RST(RST), .PC_LOAD(PC_LOAD), .PC_LOAD_ADDR(PC_LOAD_ADDR),
    .BOUND_EN(bound_en), .SLOW(slow), .CORE_PC(CORE_PC), .CORE_BOUNDARY(CORE_BOUNDARY));

  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end

  always @(posedge CLK) begin
    if (PC_LOAD === 1'b1) begin
      n_loads   <= n_loads + 1;
      last_addr <= PC_LOAD_ADDR;
    end
  end

  task automatic report_and_stop();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic hung(input string what);
    bad_count++;
    $display("unexpected at %0t: no answer in %s", $time, what);
    report_and_stop();
  endtask

  // both channels offered together; each released at the edge that takes it
  task automatic wr(input int idx, input logic [7:0] v);
    logic a_t, w_t, got;
    @(posedge CLK);
    AWVALID <= 1'b1;
    WVALID  <= 1'b1;
    BREADY  <= 1'b1;
    AWADDR  <= 8'(idx * 4);
    WDATA   <= {24'h0, v};
    WSTRB   <= 4'hf;
    got = 1'b0;
    for (int k = 0; k < 50 && !got; k++) begin
      #1;
      a_t = AWVALID && AWREADY === 1'b1;
      w_t = WVALID && WREADY === 1'b1;
      got = BVALID === 1'b1;
      r = BRESP;
      @(posedge CLK);
      if (a_t) AWVALID <= 1'b0;
      if (w_t) WVALID <= 1'b0;
    end
    BREADY <= 1'b0;
    if (!got) hung("write");
  endtask

  task automatic rchk(input int idx, input logic [31:0] exp);
    logic a_t, got;
    @(posedge CLK);
    ARVALID <= 1'b1;
    RREADY  <= 1'b1;
    ARADDR  <= 8'(idx * 4);
    got = 1'b0;
    for (int k = 0; k < 50 && !got; k++) begin
      #1;
      a_t = ARVALID && ARREADY === 1'b1;
      got = RVALID === 1'b1;
      d = RDATA;
      r = RRESP;
      @(posedge CLK);
      if (a_t) ARVALID <= 1'b0;
    end
    RREADY <= 1'b0;
    if (!got) hung("read");
    chk(d, exp, "read data");
    chk(32'(r), 32'(idx < 11 ? PVIU_RESP_OKAY : PVIU_RESP_SLVERR), "read resp");
  endtask

  task automatic wait_load(input int target);
    for (int k = 0; k < 40 && n_loads < target; k++) begin
      @(posedge CLK);
      #1;
    end
    if (n_loads < target) hung("vector load");
  endtask

  task automatic pulse(input int k);
    @(posedge CLK);
    CORE_CALL <= (k == 0);
    CORE_RET  <= (k == 1);
    CORE_RETURN_FROM_INTERRUPT <= (k == 2);
    @(posedge CLK);
    {CORE_CALL, CORE_RET, CORE_RETURN_FROM_INTERRUPT} <= 3'b000;
  endtask

  initial begin
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, CORE_CALL, CORE_RET, CORE_RETURN_FROM_INTERRUPT} = '0;
    {AWADDR, ARADDR, WDATA, WSTRB, INT_PIN, bound_en, slow} = '0;
    ev = '0;
    RST = 1'b1;
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    for (int i = 0; i < 11; i++) rchk(i, 0);
    wr(11, 8'hff);
    chk(32'(r), 32'(PVIU_RESP_SLVERR), "unmapped write");
    rchk(11, 0);
    for (int i = 0; i < 11; i++) wr(i, 8'hff);
    for (int i = 0; i < 11; i++) rchk(i, 32'(PVIU_WMASK[i]));
    for (int i = 10; i >= 0; i--) wr(i, 8'h00);
    for (int i = 0; i < 11; i++) rchk(i, 0);
    $display("test registers done");
    bound_en <= 1'b1;
    wr(0, 8'h01);
    @(posedge CLK);
    ev.usb <= 1'b1;
    @(posedge CLK);
    ev <= '0;
    #1;
    chk(32'(WAKE), 1, "wake");
    repeat (5) @(posedge CLK);
    rchk(0, 8'h41);
    chk(32'(n_loads), 0, "disabled source");
    wr(0, 8'h00);
    wr(1, 8'h13);
    repeat (5) @(posedge CLK);
    chk(32'(n_loads), 0, "global off");
    wr(0, 8'h49);
    wait_load(1);
    chk(32'(last_addr), 32'h0c, "usb vector");
    rchk(0, 8'h08);
    @(posedge CLK);
    ev.cmp1 <= 1'b1;
    @(posedge CLK);
    ev <= '0;
    rchk(1, 8'h33);
    pulse(2);
    wait_load(2);
    chk(32'(last_addr), 32'h0100, "return");
    slow <= 1'b1;
    wr(0, 8'h09);
    wait_load(3);
    chk(32'(last_addr), 32'h10, "cmp0 vector");
    rchk(1, 8'h23);
    pulse(2);
    wait_load(4);
    chk(32'(last_addr), 32'h0101, "return");
    wr(1, 8'h00);
    slow <= 1'b0;
    $display("test service done");
    for (int n = 0; n < 6; n++) begin
      wr(4 + n, 8'h11);
      rchk(pidx[n], 32'(pbit[n]));
      wr(4 + n, 8'h00);
      wr(pidx[n], 8'h00);
    end
    wr(9, 8'h01);
    @(posedge CLK);
    ev.low_voltage <= 1'b1;
    @(posedge CLK);
    ev <= '0;
    wr(3, 8'h08);
    wr(0, 8'h01);
    wait_load(5);
    chk(32'(last_addr), 32'h3c, "grouped vector");
    rchk(9, 8'h11);
    rchk(3, 8'h88);
    pulse(2);
    wait_load(6);
    chk(32'(last_addr), 32'h0102, "return");
    wr(9, 8'h00);
    wr(3, 8'h00);
    $display("test grouped done");
    for (int c = 0; c < 4; c++) begin
      wr(10, 8'(c));
      wr(0, 8'h00);
      @(posedge CLK);
      INT_PIN <= 2'b01;
      repeat (6) @(posedge CLK);
      rchk(0, 32'(c % 2) << 4);
      wr(0, 8'h00);
      @(posedge CLK);
      INT_PIN <= 2'b00;
      repeat (6) @(posedge CLK);
      rchk(0, 32'(c / 2) << 4);
    end
    wr(10, 8'h00);
    wr(0, 8'h00);
    $display("test pins done");
    pulse(0);
    pulse(0);
    #1;
    chk(32'(STACK_FULL), 1, "stack full");
    wr(0, 8'h49);
    repeat (8) @(posedge CLK);
    chk(32'(n_loads), 6, "held while full");
    pulse(1);
    wait_load(7);
    chk(32'(last_addr), 32'h0103, "pop");
    wait_load(8);
    chk(32'(last_addr), 32'h0c, "after pop");
    $display("test stack done");
    report_and_stop();
  end
endmodule

`default_nettype wire
